// ### verilog/pcf_regs.svh
// register indices, field positions, reset values and timing of the compensation filter
// assumes inclusion by bare name from the filter module and the testbench top
`ifndef PCF_REGS_SVH
`define PCF_REGS_SVH

// ------------------------------------------------------------
// register indices (byte address is four times the index)
// ------------------------------------------------------------
`define PCF_IDX_ZERO 8'h20
`define PCF_IDX_POLE 8'h21
`define PCF_IDX_GAIN 8'h22
`define PCF_IDX_STAT 8'h23
`define PCF_ADDR_LSB 2
`define PCF_ADDR_MSB 9

// ------------------------------------------------------------
// fields and reset values
// ------------------------------------------------------------
`define PCF_COEF_RESET 8'h00
`define PCF_STAT_SAT_BIT 8
`define PCF_ZP_SHIFT 8
`define PCF_GAIN_SHIFT 2
`define PCF_CMD_MAX 8'sh7f
`define PCF_CMD_MIN 8'sh80

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define PCF_SAMPLE_NS 520000
`define PCF_CLK_NS 20

`endif

// ### verilog/pcf_pkg.sv
// types shared by the compensation filter
// assumes the register header is on the include path
`default_nettype none

package pcf_pkg;
    // coefficient set as programmed by software
    typedef struct packed {
        logic [7:0] gain;
        logic [7:0] pole;
        logic [7:0] zero;
    } pcf_coef_t;

    // apb request fields travelling together
    typedef struct packed {
        logic [31:0] paddr;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
        logic pwrite;
    } pcf_apb_req_t;
endpackage

`default_nettype wire

// ### verilog/pcf_filter.sv
// lead compensation filter with apb coefficient registers
// assumes pos_err is synchronous to pclk and stable around each sample tick
//
// Decided for this implementation: the APB interface to the registers.
`default_nettype none
`include "pcf_regs.svh"

module pcf_filter #(
    parameter int ERR_W = 16,
    parameter int SAMPLE_CYCLES = `PCF_SAMPLE_NS / `PCF_CLK_NS
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire pcf_pkg::pcf_apb_req_t apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // loop
    input wire logic signed [ERR_W-1:0] pos_err,
    output logic signed [7:0] motor_cmd,
    output logic cmd_strobe
);
    import pcf_pkg::*;

    localparam int DW = ERR_W + 10;
    localparam int AW = ERR_W + 20;
    localparam int CW = $clog2(SAMPLE_CYCLES);

    // refuse widths and periods the datapath and counters cannot hold
    if (ERR_W < 2 || ERR_W > 24 || SAMPLE_CYCLES < 2) begin : bad_params
        $error("pcf_filter: unsupported parameter values");
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] reg_index(input logic [31:0] addr);
        reg_index = addr[`PCF_ADDR_MSB:`PCF_ADDR_LSB];
    endfunction

    function automatic logic signed [7:0] clamp8(input logic signed [AW-1:0] v);
        if (v > AW'(`PCF_CMD_MAX)) begin
            clamp8 = `PCF_CMD_MAX;
        end else if (v < AW'(`PCF_CMD_MIN)) begin
            clamp8 = `PCF_CMD_MIN;
        end else begin
            clamp8 = v[7:0];
        end
    endfunction

    function automatic logic is_mapped(input logic [7:0] idx);
        is_mapped = (idx == `PCF_IDX_ZERO) || (idx == `PCF_IDX_POLE) ||
                    (idx == `PCF_IDX_GAIN) || (idx == `PCF_IDX_STAT);
    endfunction

    pcf_coef_t coef;
    logic signed [ERR_W-1:0] x_prev;
    logic sat_flag;
    logic [CW-1:0] period_cnt;
    logic sample_tick;
    logic signed [DW-1:0] zero_out;
    logic signed [AW-1:0] acc;
    logic signed [AW-1:0] scaled;
    logic [7:0] idx;
    logic wr_fire;

    assign idx = reg_index(apb_req.paddr);
    assign wr_fire = psel && penable && pready && apb_req.pwrite && apb_req.pstrb[0];

    // ------------------------------------------------------------
    // apb slave: one wait-free access phase
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !is_mapped(idx);
            if (psel && !penable && !apb_req.pwrite) begin
                case (idx)
                    `PCF_IDX_ZERO: prdata <= {24'h00_0000, coef.zero};
                    `PCF_IDX_POLE: prdata <= {24'h00_0000, coef.pole};
                    `PCF_IDX_GAIN: prdata <= {24'h00_0000, coef.gain};
                    `PCF_IDX_STAT: prdata <= {23'h00_0000, sat_flag, motor_cmd};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // coefficient registers; narrow value sits in byte lane 0
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            coef <= {`PCF_COEF_RESET, `PCF_COEF_RESET, `PCF_COEF_RESET};
        end else if (wr_fire) begin
            case (idx)
                `PCF_IDX_ZERO: coef.zero <= apb_req.pwdata[7:0];
                `PCF_IDX_POLE: coef.pole <= apb_req.pwdata[7:0];
                `PCF_IDX_GAIN: coef.gain <= apb_req.pwdata[7:0];
                default: coef <= coef;
            endcase
        end
    end

    // ------------------------------------------------------------
    // sample timer
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_cnt <= '0;
            sample_tick <= 1'b0;
        end else begin
            sample_tick <= (period_cnt == CW'(SAMPLE_CYCLES - 1));
            if (period_cnt == CW'(SAMPLE_CYCLES - 1)) begin
                period_cnt <= '0;
            end else begin
                period_cnt <= period_cnt + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // difference equation, scaled by 1024 to stay in integers
    // y = (K/4)(x - (A/256) x_prev) - (B/256) y_prev
    // ------------------------------------------------------------
    always_comb begin
        // operands widened first so products keep every bit
        zero_out = (DW'(pos_err) <<< `PCF_ZP_SHIFT) -
                   (DW'($signed({1'b0, coef.zero})) * DW'(x_prev));
        acc = (AW'($signed({1'b0, coef.gain})) * AW'(zero_out)) -
              ((AW'($signed({1'b0, coef.pole})) * AW'(motor_cmd)) <<< `PCF_GAIN_SHIFT);
        scaled = acc >>> (`PCF_ZP_SHIFT + `PCF_GAIN_SHIFT);
    end

    // clamped output doubles as pole state, so the loop cannot run away on wrap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            motor_cmd <= 8'sh00;
            x_prev <= '0;
            sat_flag <= 1'b0;
            cmd_strobe <= 1'b0;
        end else begin
            cmd_strobe <= sample_tick;
            if (sample_tick) begin
                motor_cmd <= clamp8(scaled);
                sat_flag <= (scaled != AW'(clamp8(scaled)));
                x_prev <= pos_err;
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    // starts at all ones so the first period after reset counts like the rest
    logic [CW:0] gap_cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_cnt <= '1;
        end else if (sample_tick) begin
            gap_cnt <= '0;
        end else begin
            gap_cnt <= gap_cnt + 1'b1;
        end
    end

    tick_period_a: assert property (@(posedge pclk) disable iff (!presetn)
        (sample_tick && $past(sample_tick, 1) == 1'b0 && gap_cnt != '0) |->
        (gap_cnt == (CW + 1)'(SAMPLE_CYCLES - 1)))
        else $error("sample tick spacing wrong");

    tick_single_a: assert property (@(posedge pclk) disable iff (!presetn)
        sample_tick |=> !sample_tick)
        else $error("sample tick longer than one cycle");

    zero_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_fire && idx == `PCF_IDX_ZERO) |=> (coef.zero == $past(apb_req.pwdata[7:0])))
        else $error("zero coefficient write lost");

    gain_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_fire && idx == `PCF_IDX_GAIN) |=> (coef.gain == $past(apb_req.pwdata[7:0])))
        else $error("gain coefficient write lost");

    cmd_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !sample_tick |=> $stable(motor_cmd))
        else $error("command changed between samples");

    strobe_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        sample_tick |=> cmd_strobe ##1 !cmd_strobe)
        else $error("command strobe misaligned");

    gain_scale_a: assert property (@(posedge pclk) disable iff (!presetn)
        (sample_tick && coef.zero == 8'h00 && coef.pole == 8'h00 &&
         pos_err == ERR_W'(4)) |=> (motor_cmd == clamp8(AW'(coef.gain))))
        else $error("gain not scaled by one quarter");

    pole_state_a: assert property (@(posedge pclk) disable iff (!presetn)
        (sample_tick && coef.gain == 8'h00 && coef.pole == 8'h80 &&
         motor_cmd == 8'sh40) |=> (motor_cmd == -8'sh20))
        else $error("pole term not minus B times last output");

    sat_high_a: assert property (@(posedge pclk) disable iff (!presetn)
        (sample_tick && scaled > AW'(`PCF_CMD_MAX)) |=> (motor_cmd == `PCF_CMD_MAX && sat_flag))
        else $error("positive overflow not clamped");

    sat_low_a: assert property (@(posedge pclk) disable iff (!presetn)
        (sample_tick && scaled < AW'(`PCF_CMD_MIN)) |=> (motor_cmd == `PCF_CMD_MIN && sat_flag))
        else $error("negative overflow not clamped");

    apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable) |=> pready ##1 !pready)
        else $error("apb ready not one access cycle");

    sat_cover_c: cover property (@(posedge pclk) disable iff (!presetn)
        sample_tick ##1 sat_flag);
    write_cover_c: cover property (@(posedge pclk) disable iff (!presetn)
        wr_fire && idx == `PCF_IDX_POLE);
    err_cover_c: cover property (@(posedge pclk) disable iff (!presetn)
        pready && pslverr);
    run_cover_c: cover property (@(posedge pclk) disable iff (!presetn)
        cmd_strobe && motor_cmd != 8'sh00);
endmodule

`default_nettype wire

// ### tb/pcf_dac_model.sv
// converter and amplifier stand-in: holds each command word as an offset-binary code
// assumes motor_cmd is valid while cmd_strobe is high
`default_nettype none
module pcf_dac_model (
    // clock
    input wire logic pclk,
    // command in
    input wire logic signed [7:0] motor_cmd,
    input wire logic cmd_strobe,
    // converter code out
    output logic [7:0] dac_code
);
    timeunit 1ns;
    timeprecision 1ns;
    // converter is unsigned, so the sign bit is flipped; 80h is zero drive
    initial dac_code = 8'h80;
    always @(posedge pclk) begin
        if (cmd_strobe === 1'b1) begin
            dac_code <= {~motor_cmd[7], motor_cmd[6:0]};
        end
    end
endmodule
`default_nettype wire

// ### tb/pcf_tb_top.sv
// self-checking bench for the compensation filter and its apb registers
// assumes the package, the filter and the converter stand-in are compiled first
`default_nettype none
`include "pcf_regs.svh"
module position_loop_comp_filter_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import pcf_pkg::*;
    localparam int SC = 20;
    logic pclk, presetn, psel, penable, pready, pslverr, cmd_strobe, err;
    pcf_apb_req_t apb_req;
    logic [31:0] prdata, rd;
    logic signed [15:0] pos_err;
    logic signed [7:0] motor_cmd, ey;
    logic [7:0] dac_code, sa, sb, sk;
    longint xp, yp, acc, cyc, last_cyc;
    int bad_count, checks, nsamp;

    pcf_filter #(.ERR_W(16), .SAMPLE_CYCLES(SC)) pcf_filter_inst (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .apb_req(apb_req),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pos_err(pos_err),
        .motor_cmd(motor_cmd), .cmd_strobe(cmd_strobe));
    pcf_dac_model pcf_dac_model_inst (.pclk(pclk), .motor_cmd(motor_cmd),
        .cmd_strobe(cmd_strobe), .dac_code(dac_code));

    // ----------------------------------------
    // clock, timeout, shared tasks
    // ----------------------------------------
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            bad_count++;
            final_report();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t %s: saw %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // held until pready is seen high, never a fixed wait
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        apb_req <= '{paddr: {22'h0, idx, 2'b00}, pwdata: wd, pstrb: 4'hf, pwrite: wr};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_samples(input int n);
        int target;
        target = nsamp + n;
        while (nsamp < target) @(negedge pclk);
    endtask
    // writes land just after a sample so none straddles a tick
    task automatic set_coefs(input logic [7:0] a, b, k, input logic signed [15:0] x);
        wait_samples(1);
        apb(1'b1, `PCF_IDX_ZERO, {24'h0, a});
        apb(1'b1, `PCF_IDX_POLE, {24'h0, b});
        apb(1'b1, `PCF_IDX_GAIN, {24'h0, k});
        sa = a;
        sb = b;
        sk = k;
        pos_err <= x;
    endtask

    // ----------------------------------------
    // reference loop, run on every sample so its state never drifts
    // ----------------------------------------
    always @(negedge pclk) begin
        if (presetn && cmd_strobe === 1'b1) begin
            acc = (longint'(sk) * (256 * longint'(pos_err) - longint'(sa) * xp)
                - 4 * longint'(sb) * yp) >>> 10;
            ey = (acc > 127) ? 8'sh7f : (acc < -128) ? 8'sh80 : acc[7:0];
            check(motor_cmd, ey, "command word");
            check(dac_code, {~yp[7], yp[6:0]}, "converter code");
            if (nsamp > 0) begin
                check(cyc - last_cyc, SC, "sample period");
            end
            xp = pos_err;
            yp = ey;
            last_cyc = cyc;
            nsamp++;
        end
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic test_regs();
        logic [7:0] i;
        for (i = `PCF_IDX_ZERO; i <= `PCF_IDX_GAIN; i++) begin
            apb(1'b0, i, 32'h0);
            check(rd, 32'h0, "reset value");
            apb(1'b1, i, 32'hffff_ffff);
            apb(1'b0, i, 32'h0);
            check({rd[30:0], err}, 32'hff << 1, "readback");
        end
        apb(1'b0, 8'h30, 32'h0);
        check({rd[30:0], err}, 32'h1, "unmapped read");
        for (i = `PCF_IDX_ZERO; i <= `PCF_IDX_GAIN; i++) apb(1'b1, i, 32'h0);
        $display("test_regs done");
    endtask
    task automatic test_filter();
        set_coefs(8'h40, 8'h20, 8'h80, 16'sd2);
        wait_samples(3);
        set_coefs(8'h40, 8'h20, 8'h80, -16'sd3);
        wait_samples(3);
        set_coefs(8'hff, 8'hff, 8'hff, 16'sd1); // boundary codes
        wait_samples(4);
        set_coefs(8'h00, 8'h00, 8'h00, 16'sd5);
        wait_samples(2);
        // gain step held over two samples, pole step checked after one, far below the sample rate
        set_coefs(8'h00, 8'h00, 8'h40, 16'sd4);
        wait_samples(2);
        check(motor_cmd, 8'sh40, "quarter gain");
        set_coefs(8'h00, 8'h80, 8'h00, 16'sd4);
        wait_samples(1);
        check(motor_cmd, -8'sh20, "pole only step");
        $display("test_filter done");
    endtask
    task automatic test_sat();
        set_coefs(8'h00, 8'h00, 8'hff, 16'sh4000);
        wait_samples(2);
        check(motor_cmd, 8'sh7f, "clamp high");
        apb(1'b0, `PCF_IDX_STAT, 32'h0);
        check(rd, 32'h0000_017f, "status after clamp");
        set_coefs(8'h00, 8'h00, 8'hff, -16'sh4000);
        wait_samples(2);
        check(motor_cmd, 8'sh80, "clamp low");
        $display("test_sat done");
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        apb_req = '0;
        pos_err = '0;
        {sa, sb, sk} = '0;
        {xp, yp, cyc, last_cyc} = '0;
        {nsamp, bad_count, checks} = '0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        test_regs();
        test_filter();
        test_sat();
        final_report();
    end
endmodule
`default_nettype wire
